// ==== rtl/pio_cell.sv ====
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "pio_map.svh"
module pio_cell #(
  parameter bit GLOBAL_VARIANT = 1'b0,
  parameter int GB_INDEX = 0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ce_i,
  input wire logic in_clk_i,
  input wire logic out_clk_i,
  input wire logic hold_i,
  input wire logic oe_i,
  input wire logic d_out0_i,
  input wire logic d_out1_i,
  output logic d_in0_o,
  output logic d_in1_o,
  output logic global_o,
  input wire logic pad_i,
  input wire logic pad_n_i,
  output logic pad_o,
  output logic pad_oen_o
);

  // ----------------------------------------
  // Registers and synchronisers
  // ----------------------------------------
  pio_pkg::pio_cfg_s cfg;
  pio_pkg::pio_status_s status;
  logic [3:0] sync_q;
  logic pad_s;
  logic pad_n_s;
  logic in_clk_s;
  logic out_clk_s;

  pio_regs u_regs (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .status_i(status),
    .rdata_o(rdata_o),
    .cfg_o(cfg)
  );

  // Pins and foreign clocks are sampled, not used as clocks
  pio_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({pad_i, pad_n_i, in_clk_i, out_clk_i}),
    .q_o(sync_q)
  );

  assign pad_s = sync_q[3];
  assign pad_n_s = sync_q[2];
  assign in_clk_s = sync_q[1];
  assign out_clk_s = sync_q[0];

  // ----------------------------------------
  // Clock edges, enable, hold
  // ----------------------------------------
  localparam bit DIFF_CAPABLE = GLOBAL_VARIANT && (GB_INDEX == `PIO_DIFF_GB_INDEX);

  logic in_lvl;
  logic out_lvl;
  logic in_prev_reg;
  logic out_prev_reg;
  logic in_rise;
  logic in_fall;
  logic out_rise;
  logic out_fall;
  logic ce_eff;
  logic hold_eff;
  logic diff_ok;
  logic pad_val;
  logic hold_val_reg;

  // Unconnected clock reads low, so no rising edges occur
  assign in_lvl = cfg.inclk_conn & (in_clk_s ^ cfg.clk_inv);
  assign out_lvl = cfg.outclk_conn & (out_clk_s ^ cfg.clk_inv);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      in_prev_reg <= 1'b0;
      out_prev_reg <= 1'b0;
    end
    else
    begin
      in_prev_reg <= in_lvl;
      out_prev_reg <= out_lvl;
    end
  end

  assign in_rise = in_lvl & ~in_prev_reg;
  assign in_fall = ~in_lvl & in_prev_reg;
  assign out_rise = out_lvl & ~out_prev_reg;
  assign out_fall = ~out_lvl & out_prev_reg;

  assign ce_eff = ~cfg.ce_conn | ce_i;
  // Single bank-wide hold input, no per-pin control
  assign hold_eff = cfg.latch_conn & hold_i;

  // Differential reception only on the capable global input
  assign diff_ok = cfg.diff_std & DIFF_CAPABLE;
  assign pad_val = diff_ok ? (pad_s & ~pad_n_s) : pad_s;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hold_val_reg <= 1'b0;
    else if (!hold_eff)
      hold_val_reg <= pad_val;
  end

  // ----------------------------------------
  // Input side
  // ----------------------------------------
  logic [1:0] in_fld;
  logic in_src;
  logic in_regd;
  logic cap0_reg;
  logic cap1_reg;

  assign in_fld = cfg.pin_type[`PIO_CFG_IN_HI:`PIO_CFG_IN_LO];
  // Latched styles read the frozen value
  assign in_src = in_fld[1] ? hold_val_reg : pad_val;
  assign in_regd = (in_fld == `PIO_IN_REG) || (in_fld == `PIO_IN_LATCH_REG);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cap0_reg <= 1'b0;
      cap1_reg <= 1'b0;
    end
    else if (ce_eff)
    begin
      if (in_rise)
        cap0_reg <= in_src;
      if (in_fall)
        cap1_reg <= in_src;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      d_in0_o <= 1'b0;
      d_in1_o <= 1'b0;
    end
    else
    begin
      d_in0_o <= in_regd ? cap0_reg : in_src;
      d_in1_o <= (in_fld == `PIO_IN_REG) ? cap1_reg : 1'b0;
    end
  end

  // Global path bypasses the input flops
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      global_o <= 1'b0;
    else if (GLOBAL_VARIANT)
      global_o <= cfg.latch_conn ? hold_val_reg : pad_val;
  end

  // ----------------------------------------
  // Output side
  // ----------------------------------------
  function automatic pio_pkg::pio_dat_e dat_mode(input logic [3:0] fld);
    unique case (fld)
      `PIO_OUT_DIRECT, `PIO_OUT_DIRECT_TRI, `PIO_OUT_DIR_REG_EN: dat_mode = pio_pkg::PIO_DAT_DIRECT;
      `PIO_OUT_REG, `PIO_OUT_REG_DIR_EN, `PIO_OUT_REG_REG_EN: dat_mode = pio_pkg::PIO_DAT_REG;
      `PIO_OUT_DDR, `PIO_OUT_DDR_DIR_EN, `PIO_OUT_DDR_REG_EN: dat_mode = pio_pkg::PIO_DAT_DDR;
      default: dat_mode = pio_pkg::PIO_DAT_NONE;
    endcase
  endfunction : dat_mode

  // Undefined codes leave the pad released, the safe choice
  function automatic pio_pkg::pio_en_e en_mode(input logic [3:0] fld);
    unique case (fld)
      `PIO_OUT_DIRECT, `PIO_OUT_REG, `PIO_OUT_DDR: en_mode = pio_pkg::PIO_EN_ON;
      `PIO_OUT_DIRECT_TRI, `PIO_OUT_REG_DIR_EN, `PIO_OUT_DDR_DIR_EN: en_mode = pio_pkg::PIO_EN_DIRECT;
      `PIO_OUT_DIR_REG_EN, `PIO_OUT_REG_REG_EN, `PIO_OUT_DDR_REG_EN: en_mode = pio_pkg::PIO_EN_REG;
      default: en_mode = pio_pkg::PIO_EN_OFF;
    endcase
  endfunction : en_mode

  logic [3:0] out_fld;
  pio_pkg::pio_dat_e dat;
  pio_pkg::pio_en_e en;
  logic q0_reg;
  logic q1_reg;
  logic oe_q_reg;
  logic dat_bit;
  logic drive;

  assign out_fld = cfg.pin_type[`PIO_CFG_OUT_HI:`PIO_CFG_OUT_LO];
  assign dat = dat_mode(out_fld);
  assign en = en_mode(out_fld);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q0_reg <= 1'b0;
      q1_reg <= 1'b0;
      oe_q_reg <= 1'b0;
    end
    else if (ce_eff)
    begin
      if (out_rise)
      begin
        q0_reg <= d_out0_i;
        oe_q_reg <= oe_i;
      end
      if (out_fall)
        q1_reg <= d_out1_i;
    end
  end

  always_comb
  begin
    unique case (dat)
      pio_pkg::PIO_DAT_DIRECT: dat_bit = d_out0_i;
      pio_pkg::PIO_DAT_REG: dat_bit = q0_reg;
      pio_pkg::PIO_DAT_DDR: dat_bit = out_lvl ? q0_reg : q1_reg;
      default: dat_bit = 1'b0;
    endcase
    unique case (en)
      pio_pkg::PIO_EN_ON: drive = 1'b1;
      pio_pkg::PIO_EN_DIRECT: drive = oe_i;
      pio_pkg::PIO_EN_REG: drive = oe_q_reg;
      default: drive = 1'b0;
    endcase
  end

  // Pad drivers registered to keep glitches off the pin
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pad_o <= 1'b0;
      pad_oen_o <= 1'b1;
    end
    else
    begin
      pad_o <= dat_bit;
      pad_oen_o <= ~drive;
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  assign status.pad = pad_val;
  assign status.din0 = d_in0_o;
  assign status.din1 = d_in1_o;
  assign status.driving = ~pad_oen_o;
  assign status.hold_active = hold_eff;
  assign status.diff_refused = cfg.diff_std & ~DIFF_CAPABLE;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_hold_two;
    hold_eff ##1 hold_eff;
  endsequence

  sequence s_ce_low_rise;
    !ce_eff && (out_rise || out_fall);
  endsequence

  a_hold_freeze: assert property (s_hold_two |-> $stable(hold_val_reg))
    else $error("held pad value moved");

  a_ce_hold_out: assert property (s_ce_low_rise |=> $stable(q0_reg) && $stable(q1_reg))
    else $error("output flops changed with enable low");

  a_ddr_rise: assert property (out_rise && ce_eff |=> q0_reg == $past(d_out0_i))
    else $error("first bit not launched on rising edge");

  a_ddr_fall: assert property (out_fall && ce_eff |=> q1_reg == $past(d_out1_i))
    else $error("second bit not launched on falling edge");

  a_cap_rise: assert property (in_rise && ce_eff && in_fld == `PIO_IN_REG |=> ##1
    d_in0_o == $past(in_src, 2))
    else $error("first input not rising edge sample");

  a_cap_fall: assert property (in_fall && ce_eff && in_fld == `PIO_IN_REG |=> ##1
    d_in1_o == $past(in_src, 2))
    else $error("second input not falling edge sample");

  a_pad_release: assert property (en == pio_pkg::PIO_EN_OFF |=> pad_oen_o)
    else $error("pad driven while output disabled");

  a_oe_direct: assert property (en == pio_pkg::PIO_EN_DIRECT |=> pad_oen_o == !$past(oe_i))
    else $error("direct enable not followed");

  a_ddr_mux: assert property (dat == pio_pkg::PIO_DAT_DDR |=>
    pad_o == ($past(out_lvl) ? $past(q0_reg) : $past(q1_reg)))
    else $error("DDR pad shows wrong bit");

  a_noclk_quiet: assert property (!cfg.outclk_conn || !cfg.inclk_conn |->
    !(out_rise && !cfg.outclk_conn) && !(in_rise && !cfg.inclk_conn))
    else $error("edge seen on unconnected clock");

  a_diff_gate: assert property (diff_ok && in_fld == `PIO_IN_DIRECT |=>
    d_in0_o == ($past(pad_s) && !$past(pad_n_s)))
    else $error("differential input not taken from pair");

endmodule : pio_cell

// ==== pkg/pio_map.svh ====
// What this block does
// - Hold control high freezes last pad value
// - One hold control shared per bank
// - One clock enable; unconnected means high
// - Enable low holds flops, high loads
// - Capture clock drives input flops; unconnected low
// - Launch clock drives output flops; unconnected low
// - Drive enable low releases pad, high drives
// - DDR first bit launched on rising edge
// - DDR second bit launched on falling edge
// - DDR first input sampled on rising edge
// - DDR second input sampled on falling edge
// - Global output from pad, frozen by hold
// - Global variant keeps all ports plus global
// - Only global input seven takes differential clock
// - Field bits 5:2 output, 1:0 input
// - Output field encodings for nine structures plus none
// - Input field encodings: direct, registered, latched
// - Clock invert option swaps edge roles
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIO_CFG_OFFSET 8'h00
`define PIO_STATUS_OFFSET 8'h04

// ----------------------------------------
// Configuration fields and reset value
// ----------------------------------------
`define PIO_CFG_OUT_HI 5
`define PIO_CFG_OUT_LO 2
`define PIO_CFG_IN_HI 1
`define PIO_CFG_IN_LO 0
`define PIO_CFG_CLK_INV 6
`define PIO_CFG_CE_CONN 7
`define PIO_CFG_INCLK_CONN 8
`define PIO_CFG_OUTCLK_CONN 9
`define PIO_CFG_LATCH_CONN 10
`define PIO_CFG_DIFF_STD 11
`define PIO_CFG_RESET 12'h001

// ----------------------------------------
// Structure encodings
// ----------------------------------------
`define PIO_OUT_NONE 4'h0
`define PIO_OUT_DIRECT 4'h6
`define PIO_OUT_DIRECT_TRI 4'hA
`define PIO_OUT_REG 4'h5
`define PIO_OUT_REG_DIR_EN 4'h9
`define PIO_OUT_DIR_REG_EN 4'hE
`define PIO_OUT_REG_REG_EN 4'hD
`define PIO_OUT_DDR 4'h4
`define PIO_OUT_DDR_DIR_EN 4'h8
`define PIO_OUT_DDR_REG_EN 4'hC
`define PIO_IN_DIRECT 2'h1
`define PIO_IN_REG 2'h0
`define PIO_IN_LATCH 2'h3
`define PIO_IN_LATCH_REG 2'h2

// ----------------------------------------
// Differential clock capable global input
// ----------------------------------------
`define PIO_DIFF_GB_INDEX 7

`endif

// ==== pkg/pio_pkg.sv ====
package pio_pkg;

  typedef enum logic [3:0] {
    PIO_DAT_NONE = 4'b0001,
    PIO_DAT_DIRECT = 4'b0010,
    PIO_DAT_REG = 4'b0100,
    PIO_DAT_DDR = 4'b1000
  } pio_dat_e;

  typedef enum logic [3:0] {
    PIO_EN_OFF = 4'b0001,
    PIO_EN_ON = 4'b0010,
    PIO_EN_DIRECT = 4'b0100,
    PIO_EN_REG = 4'b1000
  } pio_en_e;

  typedef struct packed {
    logic diff_std;
    logic latch_conn;
    logic outclk_conn;
    logic inclk_conn;
    logic ce_conn;
    logic clk_inv;
    logic [5:0] pin_type;
  } pio_cfg_s;

  typedef struct packed {
    logic diff_refused;
    logic hold_active;
    logic driving;
    logic din1;
    logic din0;
    logic pad;
  } pio_status_s;

endpackage : pio_pkg

// ==== rtl/pio_sync.sv ====
`timescale 1ns/10ps
module pio_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------
  // Two stage synchroniser
  // ----------------------------------------
  // First stage feeds only the second
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_reg <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : pio_sync

// ==== rtl/pio_regs.sv ====
`timescale 1ns/10ps
`include "pio_map.svh"
module pio_regs (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input pio_pkg::pio_status_s status_i,
  output logic [31:0] rdata_o,
  output pio_pkg::pio_cfg_s cfg_o
);

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cfg_o <= pio_pkg::pio_cfg_s'(`PIO_CFG_RESET);
    else if (wr_i && addr_i == `PIO_CFG_OFFSET)
      cfg_o <= pio_pkg::pio_cfg_s'(wdata_i[11:0]);
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      if (addr_i == `PIO_CFG_OFFSET)
        rdata_o <= {20'h0_0000, cfg_o};
      else if (addr_i == `PIO_STATUS_OFFSET)
        rdata_o <= {26'h000_0000, status_i};
      else
        rdata_o <= 32'h0000_0000;
    end
    else
      rdata_o <= 32'h0000_0000;
  end

endmodule : pio_regs

// ==== test/pio_board.sv ====
`timescale 1ns/10ps
module pio_board (
  input wire logic clk_i,
  input wire logic pad_o,
  input wire logic pad_oen_o,
  input wire logic drv_en_i,
  input wire logic drv_val_i,
  output logic pad_i,
  output logic pad_n_i
);
  // ----------------------------------------
  // Board wire
  // ----------------------------------------
  // No pull on the trace: a floating pad wanders every cycle
  logic float_reg = 1'b0;

  always @(posedge clk_i)
  begin
    float_reg <= ~float_reg;
  end

  always_comb
  begin
    if (!pad_oen_o)
      pad_i = pad_o;
    else if (drv_en_i)
      pad_i = drv_val_i;
    else
      pad_i = float_reg;
    pad_n_i = ~pad_i;
  end
endmodule : pio_board

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  typedef struct {int sel; logic [31:0] exp;} pio_note_s;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0, ce_i = 1'b0, in_clk_i = 1'b0, out_clk_i = 1'b0;
  logic hold_i = 1'b0, oe_i = 1'b0, d_out0_i = 1'b0, d_out1_i = 1'b0;
  logic drv_en = 1'b1, drv_val = 1'b0;
  logic [31:0] rdata_o, rnd;
  logic d_in0_o, d_in1_o, global_o, pad_i, pad_n_i, pad_o, pad_oen_o;
  int errors = 0;
  int checked = 0;
  int seed = 32'h90b6;
  pio_note_s notes[$];
  pio_note_s n;
  string nm [6] = '{"rdata", "pad", "pad_oen", "d_in0", "d_in1", "global"};

  pio_cell #(.GLOBAL_VARIANT(1'b1), .GB_INDEX(7)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ce_i(ce_i), .in_clk_i(in_clk_i), .out_clk_i(out_clk_i), .hold_i(hold_i), .oe_i(oe_i),
    .d_out0_i(d_out0_i), .d_out1_i(d_out1_i), .d_in0_o(d_in0_o), .d_in1_o(d_in1_o),
    .global_o(global_o), .pad_i(pad_i), .pad_n_i(pad_n_i), .pad_o(pad_o),
    .pad_oen_o(pad_oen_o));
  pio_board partner (.clk_i(clk_i), .pad_o(pad_o), .pad_oen_o(pad_oen_o),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .pad_i(pad_i), .pad_n_i(pad_n_i));

  // ----------------------------------------
  // Clock, checking and verdict
  // ----------------------------------------
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] obs(input int sel);
    case (sel)
      0: return rdata_o;
      1: return {31'h0, pad_o};
      2: return {31'h0, pad_oen_o};
      3: return {31'h0, d_in0_o};
      4: return {31'h0, d_in1_o};
      default: return {31'h0, global_o};
    endcase
  endfunction : obs

  task automatic check(input int sel, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm[sel], exp, seen);
    end
  endtask : check

  // Results settle well before the falling edge
  always @(negedge clk_i)
  begin
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      check(n.sel, obs(n.sel), n.exp);
    end
  end

  task automatic final_report();
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask : cyc

  task automatic expect_v(input int sel, input logic [31:0] v);
    notes.push_back('{sel, v});
  endtask : expect_v

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    expect_v(0, e);
  endtask : rd

  task automatic set_cfg(input logic [11:0] c);
    wr(8'h00, {20'h0, c});
    rd(8'h00, {20'h0, c});
    cyc(4);
  endtask : set_cfg

  // Launch clock half periods well above the three cycle detection delay
  task automatic pulse();
    out_clk_i <= 1'b1;
    cyc(6);
    out_clk_i <= 1'b0;
    cyc(6);
  endtask : pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    cyc(3);
    rstn_i <= 1'b1;
    expect_v(2, 32'h1);
    rd(8'h00, 32'h001);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = $random(seed);
      drv_val <= rnd[0];
      cyc(6);
      expect_v(3, rnd & 32'h1);
      expect_v(5, rnd & 32'h1);
    end
    set_cfg(12'h403);
    drv_val <= 1'b1;
    cyc(6);
    hold_i <= 1'b1;
    cyc(2);
    drv_val <= 1'b0;
    cyc(6);
    expect_v(3, 32'h1);
    expect_v(5, 32'h1);
    hold_i <= 1'b0;
    cyc(6);
    expect_v(3, 32'h0);
    drv_en <= 1'b0;
    set_cfg(12'h019);
    for (int i = 0; i < 4; i++)
    begin
      rnd = $random(seed);
      d_out0_i <= rnd[0];
      cyc(3);
      expect_v(1, rnd & 32'h1);
      expect_v(2, 32'h0);
    end
    set_cfg(12'h029);
    cyc(3);
    expect_v(2, 32'h1);
    oe_i <= 1'b1;
    cyc(3);
    expect_v(2, 32'h0);
    set_cfg(12'h001);
    expect_v(2, 32'h1);
    // Clock enable left low here: unconnected enable must act high
    for (int inv = 0; inv < 2; inv++)
    begin
      set_cfg(inv == 1 ? 12'h251 : 12'h211);
      for (int k = 0; k < 4; k++)
      begin
        d_out0_i <= k[0];
        d_out1_i <= k[1];
        out_clk_i <= 1'b1;
        cyc(6);
        expect_v(1, inv == 1 ? (k >> 1) & 1 : k & 1);
        out_clk_i <= 1'b0;
        cyc(6);
        expect_v(1, inv == 1 ? k & 1 : (k >> 1) & 1);
      end
    end
    set_cfg(12'h295);
    ce_i <= 1'b1;
    d_out0_i <= 1'b1;
    pulse();
    expect_v(1, 32'h1);
    ce_i <= 1'b0;
    d_out0_i <= 1'b0;
    pulse();
    expect_v(1, 32'h1);
    ce_i <= 1'b1;
    pulse();
    expect_v(1, 32'h0);
    set_cfg(12'h095);
    d_out0_i <= 1'b1;
    pulse();
    expect_v(1, 32'h0);
    drv_en <= 1'b1;
    set_cfg(12'h100);
    for (int k = 0; k < 4; k++)
    begin
      drv_val <= k[0];
      cyc(3);
      in_clk_i <= 1'b1;
      cyc(6);
      drv_val <= k[1];
      cyc(3);
      in_clk_i <= 1'b0;
      cyc(6);
      expect_v(3, k & 1);
      expect_v(4, (k >> 1) & 1);
    end
    // Registered enables latch oe_i only on a launch rise
    set_cfg(12'h235);
    oe_i <= 1'b0;
    d_out0_i <= 1'b0;
    pulse();
    expect_v(2, 32'h1);
    expect_v(1, 32'h0);
    oe_i <= 1'b1;
    d_out0_i <= 1'b1;
    pulse();
    expect_v(2, 32'h0);
    expect_v(1, 32'h1);
    set_cfg(12'h239);
    oe_i <= 1'b0;
    d_out0_i <= 1'b0;
    cyc(3);
    expect_v(1, 32'h0);
    expect_v(2, 32'h0);
    pulse();
    expect_v(2, 32'h1);
    set_cfg(12'h225);
    oe_i <= 1'b1;
    d_out0_i <= 1'b1;
    cyc(3);
    expect_v(2, 32'h0);
    expect_v(1, 32'h0);
    pulse();
    expect_v(1, 32'h1);
    set_cfg(12'h221);
    oe_i <= 1'b0;
    cyc(3);
    expect_v(2, 32'h1);
    set_cfg(12'h231);
    expect_v(2, 32'h0);
    // Latched registered input captures the frozen value
    set_cfg(12'h502);
    drv_val <= 1'b1;
    cyc(6);
    hold_i <= 1'b1;
    cyc(2);
    drv_val <= 1'b0;
    cyc(3);
    in_clk_i <= 1'b1;
    cyc(6);
    expect_v(3, 32'h1);
    hold_i <= 1'b0;
    in_clk_i <= 1'b0;
    cyc(6);
    in_clk_i <= 1'b1;
    cyc(6);
    expect_v(3, 32'h0);
    // Differential pair on the capable global input
    drv_val <= 1'b1;
    set_cfg(12'h801);
    expect_v(3, 32'h1);
    rd(8'h04, 32'h03);
    drv_val <= 1'b0;
    cyc(6);
    expect_v(3, 32'h0);
    cyc(2);
    final_report();
  end
endmodule : testbench
